// file: async_static_ram_2k_x8_port_test.sv
// Self-checking bench for the static RAM controller
`timescale 1ns/1ps
`default_nettype none
module async_static_ram_2k_x8_port_test;
  logic clk, reset_n, req_valid, req_write, req_ready, rsp_valid, slow;
  logic sram_cs_n, sram_oe_n, sram_we_n, sram_data_oe;
  logic [10:0] req_addr, sram_addr;
  logic [7:0] req_wdata, rsp_rdata, sram_data_out, sram_data_in;
  logic [7:0] shadow [0:2047];
  logic [7:0] expq [$];
  logic [31:0] r;
  integer failures, n_tests, cycles, i, seed;
  sramc_ctrl i_dut (.clk(clk), .reset_n(reset_n), .req_valid(req_valid),
    .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .sram_addr(sram_addr),
    .sram_cs_n(sram_cs_n), .sram_oe_n(sram_oe_n), .sram_we_n(sram_we_n),
    .sram_data_out(sram_data_out), .sram_data_oe(sram_data_oe), .sram_data_in(sram_data_in));
  sramc_mem_model i_mem (.clk(clk), .slow(slow), .addr(sram_addr), .cs_n(sram_cs_n),
    .oe_n(sram_oe_n), .we_n(sram_we_n), .host_data(sram_data_out),
    .host_oe(sram_data_oe), .data_in(sram_data_in));
  // ==========
  // Clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Compare and count
  task check(input logic [7:0] seen, input logic [7:0] want);
    n_tests = n_tests + 1;
    if (seen !== want || ^seen === 1'bx) begin
      failures = failures + 1;
      $display("CHECK FAILED %0t seen %h want %h", $time, seen, want);
    end
  endtask
  // Verdict
  task report_and_stop;
    if (failures == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // One request, held until taken, expectation noted
  task do_req(input logic w, input logic [10:0] a, input logic [7:0] d);
    req_valid = 1'b1;
    req_write = w;
    req_addr = a;
    req_wdata = d;
    while (req_ready !== 1'b1)
      @(negedge clk);
    @(negedge clk);
    if (w)
      shadow[a] = d;
    else
      expq.push_back(shadow[a]);
  endtask
  // Read results against the oldest note, and the hang limit
  always @(negedge clk) begin
    cycles = cycles + 1;
    if (rsp_valid === 1'b1)
      check(rsp_rdata, expq.size() ? expq.pop_front() : ~rsp_rdata);
    if (cycles == 4000) begin
      failures = failures + 1;
      report_and_stop;
    end
  end
  // ==========
  // Main sequence
  initial begin
    seed = 32'hAA8C;
    failures = 0;
    n_tests = 0;
    cycles = 0;
    reset_n = 1'b0;
    req_valid = 1'b0;
    req_write = 1'b0;
    req_addr = 11'h000;
    req_wdata = 8'h00;
    slow = 1'b0;
    for (i = 0; i < 2048; i++)
      shadow[i] = i[7:0] ^ 8'hA5;
    repeat (10) @(negedge clk);
    reset_n = 1'b1;
    do_req(1'b1, 11'h000, 8'h5A);
    do_req(1'b1, 11'h7FF, 8'hC3);
    do_req(1'b0, 11'h7FF, 8'h00);
    do_req(1'b0, 11'h000, 8'h00);
    do_req(1'b0, 11'h001, 8'h00);
    for (i = 0; i < 60; i++) begin
      r = $random(seed);
      slow = r[21];
      do_req(r[0], {8'h00, r[3:1]} ^ {r[20], 10'h000}, r[19:12]);
      if (r[22]) begin
        req_valid = 1'b0;
        @(negedge clk);
      end
    end
    req_valid = 1'b0;
    while (expq.size() != 0)
      @(negedge clk);
    report_and_stop;
  end
endmodule // async_static_ram_2k_x8_port_test
`default_nettype wire

// file: sramc_ctrl.v
// Host controller that runs read and write cycles on a 2K x 8 static RAM
`timescale 1ns/1ps
`default_nettype none
`include "sramc_defines.vh"

module sramc_ctrl (
  // Clock and reset
  input wire clk,
  input wire reset_n,
  // User request
  input wire req_valid,
  input wire req_write,
  input wire [`SRAMC_ADDR_W-1:0] req_addr,
  input wire [`SRAMC_DATA_W-1:0] req_wdata,
  output reg req_ready,
  // User response
  output reg rsp_valid,
  output reg [`SRAMC_DATA_W-1:0] rsp_rdata,
  // Memory pins
  output reg [`SRAMC_ADDR_W-1:0] sram_addr,
  output reg sram_cs_n,
  output reg sram_oe_n,
  output reg sram_we_n,
  output reg [`SRAMC_DATA_W-1:0] sram_data_out,
  output reg sram_data_oe,
  input wire [`SRAMC_DATA_W-1:0] sram_data_in
);

  // ==========================================================
  // Cycle plan, in edges after the take edge T
  // ==========================================================
  // Reset
  //   All strobes high and the host off the pins, so the device floats
  //   Ready rises on the first edge after release
  // Read
  //   T      address set, select and output enable fall, ready drops
  //   T+1    address, select and output enable held from here on
  //   T+13   data sampled, response pulsed, both strobes raised
  //   T+19   ready rises; earliest next take at T+20
  // Write
  //   T      address and data set, host drives the pins, select falls
  //   T+1    address and data held unchanged up to T+15
  //   T+3    write enable falls; the setup phase keeps address ahead
  //   T+13   write enable rises, ending the write interval
  //   T+15   select rises and the host stops driving, after recovery
  //   T+21   ready rises; earliest next take at T+22
  // Turnaround
  //   At least seven deselected cycles follow every cycle, longer than the worst
  //   float time, so the pins are free before the host drives again
  // Limitations
  //   Writes always keep output enable high; the low-enable write
  //   style is legal but unused, so the device never drives in a write
  //   Every phase runs one cycle past its figure, trading bandwidth
  //   for margin on every minimum
  //   Read data is taken as a synchronous input on the sampling edge
  //   No request is refused; it simply waits while ready is low

  // ==========================================================
  // States and phase lengths
  // ==========================================================
  localparam [5:0] ST_IDLE = 6'h01;
  localparam [5:0] ST_READ = 6'h02;
  localparam [5:0] ST_WSETUP = 6'h04;
  localparam [5:0] ST_WPULSE = 6'h08;
  localparam [5:0] ST_WRECOV = 6'h10;
  localparam [5:0] ST_TURN = 6'h20;

  // Phase lengths in clock cycles, worked out from the figures
  localparam integer READ_CYC = `SRAMC_READ_CYC;
  localparam integer SETUP_CYC = `SRAMC_SETUP_CYC;
  localparam integer PULSE_CYC = `SRAMC_PULSE_CYC;
  localparam integer RECOV_CYC = `SRAMC_RECOV_CYC;
  localparam integer TURN_CYC = `SRAMC_TURN_CYC;

  // Timer load values at full integer width
  localparam integer READ_LD = READ_CYC - 1;
  localparam integer SETUP_LD = SETUP_CYC - 1;
  localparam integer PULSE_LD = PULSE_CYC - 1;
  localparam integer RECOV_LD = RECOV_CYC - 1;
  localparam integer TURN_LD = TURN_CYC - 1;

  // Load values cut to the counter width on purpose; all fit easily
  // A phase loaded with N lasts N + 2 cycles: one edge for the load to
  // reach the counter, N edges of counting, and one edge to act on done
  localparam [`SRAMC_CNT_W-1:0] LD_READ = READ_LD[`SRAMC_CNT_W-1:0];
  localparam [`SRAMC_CNT_W-1:0] LD_SETUP = SETUP_LD[`SRAMC_CNT_W-1:0];
  localparam [`SRAMC_CNT_W-1:0] LD_PULSE = PULSE_LD[`SRAMC_CNT_W-1:0];
  localparam [`SRAMC_CNT_W-1:0] LD_RECOV = RECOV_LD[`SRAMC_CNT_W-1:0];
  localparam [`SRAMC_CNT_W-1:0] LD_TURN = TURN_LD[`SRAMC_CNT_W-1:0];

  reg [5:0] state;
  reg tmr_load;
  reg [`SRAMC_CNT_W-1:0] tmr_value;
  wire tmr_done;
  wire phase_end;

  // ==========================================================
  // Phase timer
  // ==========================================================
  sramc_timer #(
    .W(`SRAMC_CNT_W)
  ) u_timer (
    .clk(clk),
    .reset_n(reset_n),
    .load(tmr_load),
    .load_value(tmr_value),
    .done(tmr_done)
  );

  // A phase ends when the count has run out, never in the load cycle
  assign phase_end = tmr_done && !tmr_load;

  // ==========================================================
  // Cycle sequencer
  // ==========================================================
  // Every pin and user output is a flip-flop set here
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= ST_IDLE;
      tmr_load <= 1'b0;
      tmr_value <= {`SRAMC_CNT_W{1'b0}};
      req_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_rdata <= {`SRAMC_DATA_W{1'b0}};
      sram_addr <= {`SRAMC_ADDR_W{1'b0}};
      sram_cs_n <= 1'b1; // Deselected, device floats
      sram_oe_n <= 1'b1;
      sram_we_n <= 1'b1;
      sram_data_out <= {`SRAMC_DATA_W{1'b0}};
      sram_data_oe <= 1'b0;
    end else begin
      tmr_load <= 1'b0;
      rsp_valid <= 1'b0;
      case (state)
        ST_IDLE: begin
          req_ready <= 1'b1;
          if (req_valid && req_ready) begin
            req_ready <= 1'b0;
            sram_addr <= req_addr;
            sram_cs_n <= 1'b0;
            tmr_load <= 1'b1;
            if (req_write) begin
              // Output enable stays high so the device never drives during a write
              sram_oe_n <= 1'b1;
              sram_we_n <= 1'b1;
              sram_data_out <= req_wdata;
              // Device already floated in the turnaround or in reset, so driving is safe
              sram_data_oe <= 1'b1;
              tmr_value <= LD_SETUP;
              state <= ST_WSETUP;
            end else begin
              // Read strobes: write enable high, select and output enable low
              sram_oe_n <= 1'b0;
              sram_we_n <= 1'b1;
              sram_data_oe <= 1'b0;
              tmr_value <= LD_READ;
              state <= ST_READ;
            end
          end
        end
        ST_READ: begin
          // Sample once the slowest of the access times has elapsed
          if (phase_end) begin
            rsp_rdata <= sram_data_in;
            rsp_valid <= 1'b1;
            sram_cs_n <= 1'b1;
            sram_oe_n <= 1'b1;
            tmr_load <= 1'b1;
            tmr_value <= LD_TURN;
            state <= ST_TURN;
          end
        end
        ST_WSETUP: begin
          // Address settles before the write pulse starts
          if (phase_end) begin
            sram_we_n <= 1'b0;
            tmr_load <= 1'b1;
            tmr_value <= LD_PULSE;
            state <= ST_WPULSE;
          end
        end
        ST_WPULSE: begin
          // Pulse covers width, select-to-end, data setup and address-to-end
          if (phase_end) begin
            sram_we_n <= 1'b1;
            tmr_load <= 1'b1;
            tmr_value <= LD_RECOV;
            state <= ST_WRECOV;
          end
        end
        ST_WRECOV: begin
          // Data and address held through recovery, which also fills the cycle
          if (phase_end) begin
            sram_cs_n <= 1'b1;
            sram_data_oe <= 1'b0;
            tmr_load <= 1'b1;
            tmr_value <= LD_TURN;
            state <= ST_TURN;
          end
        end
        ST_TURN: begin
          // Deselected gap lets the device float before the host drives again
          if (phase_end) begin
            req_ready <= 1'b1;
            state <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
          req_ready <= 1'b0;
          sram_cs_n <= 1'b1;
          sram_oe_n <= 1'b1;
          sram_we_n <= 1'b1;
          sram_data_oe <= 1'b0;
        end
      endcase
    end
  end

endmodule // sramc_ctrl

`default_nettype wire

// file: sramc_ctrl_properties.sv
// Pin protocol checks for the static RAM controller
`timescale 1ns/1ps
`default_nettype none
module sramc_props (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // User side
  input wire logic req_valid,
  input wire logic req_ready,
  input wire logic rsp_valid,
  input wire logic [7:0] rsp_rdata,
  // Memory pins
  input wire logic [10:0] sram_addr,
  input wire logic sram_cs_n,
  input wire logic sram_oe_n,
  input wire logic sram_we_n,
  input wire logic [7:0] sram_data_out,
  input wire logic sram_data_oe,
  input wire logic [7:0] sram_data_in
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // ==========
  // Write cycle shape
  we_in_sel_a: assert property (!sram_we_n |-> !sram_cs_n && sram_oe_n && sram_data_oe)
    else $error("write strobe outside select");
  we_start_a: assert property ($fell(sram_we_n) |->
    !$past(sram_cs_n, 2) && $stable(sram_addr))
    else $error("write strobe before select");
  pulse_len_a: assert property ($fell(sram_we_n) |-> !sram_we_n[*7])
    else $error("write pulse short");
  data_setup_a: assert property ($rose(sram_we_n) |-> $past(sram_data_oe, 4)
    && $past(sram_data_out, 4) == sram_data_out)
    else $error("write data setup short");
  data_hold_a: assert property ($rose(sram_we_n) |-> sram_data_oe && !sram_cs_n ##1
    sram_data_oe && !sram_cs_n ##1 sram_cs_n && !sram_data_oe)
    else $error("write recovery wrong");
  // ==========
  // Cycle and read timing
  cycle_len_a: assert property ($fell(sram_cs_n) && !sram_oe_n |->
    !sram_cs_n[*8] ##1 !sram_cs_n[*5] ##1 sram_cs_n)
    else $error("read cycle length wrong");
  write_len_a: assert property ($fell(sram_cs_n) && sram_oe_n |->
    !sram_cs_n[*8] ##1 !sram_cs_n[*7] ##1 sram_cs_n)
    else $error("write cycle length wrong");
  addr_hold_a: assert property (!sram_cs_n && !$fell(sram_cs_n) |-> $stable(sram_addr))
    else $error("address moved in cycle");
  turn_gap_a: assert property ($rose(sram_cs_n) |-> sram_cs_n[*6])
    else $error("deselect gap short");
  read_data_a: assert property ($fell(sram_cs_n) && !sram_oe_n |->
    !rsp_valid[*8] ##1 !rsp_valid[*5] ##1 rsp_valid && rsp_rdata == $past(sram_data_in))
    else $error("read answer wrong");
  no_clash_a: assert property (!sram_oe_n |-> sram_we_n && !sram_cs_n && !sram_data_oe)
    else $error("host drives during read");
  // Main scenarios
  cover property (req_valid && req_ready);
  cover property ($rose(sram_we_n));
  cover property (rsp_valid);
  cover property ($fell(sram_cs_n) && sram_oe_n);
endmodule // sramc_props
bind sramc_ctrl sramc_props i_props (.clk(clk), .reset_n(reset_n), .req_valid(req_valid),
  .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .sram_addr(sram_addr),
  .sram_cs_n(sram_cs_n), .sram_oe_n(sram_oe_n), .sram_we_n(sram_we_n),
  .sram_data_out(sram_data_out), .sram_data_oe(sram_data_oe), .sram_data_in(sram_data_in));
`default_nettype wire

// file: sramc_defines.vh
// Constants and timing counts for the static RAM host controller
//
// Summary of operation
// - Array is written only during overlap of chip select low and write enable low.
// - Write recovery of 5 ns follows the first rising strobe of a write.
// - Write data is valid at least 35 ns before the write interval ends.
// - Write data is held at least 5 ns after the write interval ends.
// - Address valid 105 ns before write end; write cycle lasts at least 120 ns.
// - Chip select low 70 ns before write end; write pulse at least 70 ns.
// - Host never drives data against device outputs around a write.
// - Writes may run with output enable low; write enable then gates drivers.
// - Host drives no opposing data while selected across an address change.
// - Read needs write enable high, select and output enable low, 120 ns cycle.
`ifndef SRAMC_DEFINES_VH
`define SRAMC_DEFINES_VH

// Widths
`define SRAMC_ADDR_W 11
`define SRAMC_DATA_W 8
`define SRAMC_CNT_W 8

// Clock
`define SRAMC_CLK_NS 10
`define SRAMC_CEIL(ns) (((ns) + `SRAMC_CLK_NS - 1) / `SRAMC_CLK_NS)
`define SRAMC_MAX(a, b) (((a) > (b)) ? (a) : (b))

// Fastest speed grade figures in ns
`define SRAMC_READ_CYCLE_NS 120
`define SRAMC_ADDRESS_ACCESS_TIME_NS 120
`define SRAMC_SELECT_ACCESS_TIME_NS 120
`define SRAMC_OE_ACCESS_NS 80
`define SRAMC_SELECT_FLOAT_NS 40
`define SRAMC_OE_FLOAT_NS 40
`define SRAMC_WRITE_FLOAT_TIME_NS 50
`define SRAMC_WRITE_CYCLE_NS 120
`define SRAMC_SELECT_TO_END_NS 70
`define SRAMC_ADDR_TO_END_NS 105
`define SRAMC_ADDR_SETUP_NS 20
`define SRAMC_WRITE_PULSE_NS 70
`define SRAMC_WRITE_RECOVERY_NS 5
`define SRAMC_WRITE_DATA_SETUP_NS 35
`define SRAMC_WRITE_DATA_HOLD_NS 5

// Cycle counts derived from the figures
`define SRAMC_SETUP_CYC `SRAMC_MAX(`SRAMC_CEIL(`SRAMC_ADDR_SETUP_NS), 1)
`define SRAMC_PULSE_CYC `SRAMC_MAX(`SRAMC_MAX(`SRAMC_CEIL(`SRAMC_WRITE_PULSE_NS), \
  `SRAMC_CEIL(`SRAMC_SELECT_TO_END_NS)), `SRAMC_MAX(`SRAMC_CEIL(`SRAMC_WRITE_DATA_SETUP_NS), \
  `SRAMC_CEIL(`SRAMC_ADDR_TO_END_NS) - `SRAMC_SETUP_CYC))
`define SRAMC_RECOV_CYC `SRAMC_MAX(`SRAMC_MAX(`SRAMC_CEIL(`SRAMC_WRITE_RECOVERY_NS), \
  `SRAMC_CEIL(`SRAMC_WRITE_DATA_HOLD_NS)), `SRAMC_MAX(1, `SRAMC_CEIL(`SRAMC_WRITE_CYCLE_NS) \
  - `SRAMC_SETUP_CYC - `SRAMC_PULSE_CYC))
`define SRAMC_READ_CYC `SRAMC_MAX(`SRAMC_MAX(`SRAMC_CEIL(`SRAMC_ADDRESS_ACCESS_TIME_NS), \
  `SRAMC_CEIL(`SRAMC_SELECT_ACCESS_TIME_NS)), `SRAMC_MAX(`SRAMC_CEIL(`SRAMC_OE_ACCESS_NS), \
  `SRAMC_CEIL(`SRAMC_READ_CYCLE_NS)))
`define SRAMC_TURN_CYC `SRAMC_MAX(`SRAMC_MAX(`SRAMC_CEIL(`SRAMC_SELECT_FLOAT_NS), \
  `SRAMC_CEIL(`SRAMC_OE_FLOAT_NS)), `SRAMC_CEIL(`SRAMC_WRITE_FLOAT_TIME_NS))

`endif

// file: sramc_mem_model.sv
// Behavioural 2K x 8 static RAM on the controller's memory pins
`timescale 1ns/1ps
`default_nettype none
module sramc_mem_model (
  // Clock and latency choice
  input wire logic clk,
  input wire logic slow,
  // Memory pins
  input wire logic [10:0] addr,
  input wire logic cs_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic [7:0] host_data,
  input wire logic host_oe,
  output logic [7:0] data_in
);
  // ==========
  // Storage and output timing
  logic [7:0] mem [0:2047];
  logic [7:0] last;
  logic [3:0] age;
  integer k;
  wire logic reading = !cs_n && !oe_n && we_n;
  wire logic shown = reading && (age >= (slow ? 4'hC : 4'h1));
  // Fill with a known pattern
  initial begin
    last = 8'h00;
    for (k = 0; k < 2048; k++)
      mem[k] = k[7:0] ^ 8'hA5;
  end
  // Store in the select and strobe overlap, age the read
  always @(posedge clk) begin
    if (!cs_n && !we_n)
      mem[addr] <= data_in;
    age <= reading ? age + {3'h0, age != 4'hF} : 4'h0;
    last <= data_in;
  end
  // Released lines show an inverted pattern
  assign data_in = host_oe ? host_data : (shown ? mem[addr] : ~last);
endmodule // sramc_mem_model
`default_nettype wire

// file: sramc_timer.v
// Down counter that times one phase of a memory cycle
`timescale 1ns/1ps
`default_nettype none
`include "sramc_defines.vh"

module sramc_timer #(
  parameter W = 8
) (
  // Clock and reset
  input wire clk,
  input wire reset_n,
  // Load and status
  input wire load,
  input wire [W-1:0] load_value,
  output wire done
);

  reg [W-1:0] count;

  // Load wins; otherwise count down to zero and stay
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      count <= {W{1'b0}};
    end else if (load) begin
      count <= load_value;
    end else if (count != {W{1'b0}}) begin
      count <= count - {{(W-1){1'b0}}, 1'b1};
    end
  end

  assign done = (count == {W{1'b0}});

endmodule // sramc_timer

`default_nettype wire
